//--- ppr_pkg.sv
// Shared types and constants for the row repair controller
package ppr_pkg;

  // ==========================================================
  // Command carrier
  typedef enum logic [3:0] {
    OP_DES, OP_NOP, OP_MRS, OP_ACT, OP_WR, OP_RD, OP_PRE, OP_REF, OP_ZQ
  } ppr_op_t;

  typedef struct packed {
    logic vld;
    ppr_op_t op;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [17:0] addr;
  } ppr_cmd_t;

  // ==========================================================
  // Mode register decode
  localparam logic [2:0] MR_SEL_KEY = 3'h0;
  localparam logic [2:0] MR_SEL_PPR = 3'h4;
  localparam int MR4_SOFT_BIT = 5;
  localparam int MR4_SELFTEST_BIT = 0;

  // ==========================================================
  // Guard keys
  localparam logic [6:0] KEY_LOW_ONES = 7'h7f;
  localparam logic [4:0] KEY_CODE1 = 5'h19;
  localparam logic [4:0] KEY_CODE2 = 5'h0f;
  localparam logic [4:0] KEY_CODE3 = 5'h17;
  localparam logic [4:0] KEY_CODE4 = 5'h07;
  localparam int KEY_CODE_LSB = 7;
  localparam int KEY_CODE_MSB = 11;

  function automatic logic [4:0] key_code(input logic [1:0] idx);
    logic [4:0] c;
    c = KEY_CODE1;
    unique case (idx)
      2'h0: c = KEY_CODE1;
      2'h1: c = KEY_CODE2;
      2'h2: c = KEY_CODE3;
      2'h3: c = KEY_CODE4;
    endcase
    return c;
  endfunction

  // ==========================================================
  // Banks and rows
  localparam int NUM_BANKS = 16;
  localparam int ROW_W = 18;
  localparam logic [17:0] ASSOC_ROW_MASK = 18'h3e003;
  localparam int DATA_BEATS = 4;

  // ==========================================================
  // Timing
  localparam longint CLK_HZ = 64'd100000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SOFT_PRE_EXIT_NS = 20;
  localparam int SOFT_PRE_EXIT_CYC = (SOFT_PRE_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint SELF_HEAL_MONO_S = 64'd10;
  localparam longint SELF_HEAL_DUAL_S = 64'd20;
  localparam longint SELF_HEAL_MONO_CYC = SELF_HEAL_MONO_S * CLK_HZ;
  localparam longint SELF_HEAL_DUAL_CYC = SELF_HEAL_DUAL_S * CLK_HZ;

  // ==========================================================
  // Controller state
  typedef enum logic [3:0] {
    ST_NORMAL, ST_SOFT_ARMED, ST_SOFT_KEYED, ST_SOFT_ACT, ST_SOFT_WL,
    ST_SOFT_DATA, ST_SOFT_DONE, ST_SOFT_FAIL, ST_BIST_ARMED, ST_BIST_RUN
  } ppr_state_t;

  typedef struct packed {
    ppr_state_t st;
    logic [3:0] seed_bank;
    logic [17:0] seed_row;
    logic hi;
    logic [1:0] beat;
    logic [15:0] rep_vld;
    logic [15:0][17:0] rep_row;
    logic mpr3_flag;
    logic alert_n;
    logic act_hit;
    logic act_assoc;
    logic commit;
  } ppr_ctrl_st_t;

  typedef struct packed {
    logic [1:0] idx;
  } ppr_key_st_t;

endpackage

//--- ppr_key_seq.sv
// Guard key sequence checker
`timescale 1ns/1ps
module ppr_key_seq (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_arm,
  input wire ppr_pkg::ppr_cmd_t i_cmd,
  output logic o_done,
  output logic o_abort
);
  ppr_pkg::ppr_key_st_t q;
  ppr_pkg::ppr_key_st_t n;
  logic match;
  logic [4:0] key_field;
  logic [2:0] seen_ff;

  // ==========================================================
  // Key match and sequencing
  always_comb begin
    n = q;
    o_done = 1'b0;
    o_abort = 1'b0;
    match = i_cmd.op == ppr_pkg::OP_MRS && {i_cmd.bg[0], i_cmd.ba} == ppr_pkg::MR_SEL_KEY
      && i_cmd.bg[1] == 1'b0 && i_cmd.addr[6:0] == ppr_pkg::KEY_LOW_ONES
      && i_cmd.addr[ppr_pkg::KEY_CODE_MSB:ppr_pkg::KEY_CODE_LSB] == ppr_pkg::key_code(q.idx);
    if (!i_arm) begin
      n.idx = 2'h0;
    end else if (i_cmd.vld && i_cmd.op != ppr_pkg::OP_DES) begin
      if (match) begin
        o_done = q.idx == 2'h3;
        n.idx = q.idx + 2'h1;
      end else begin
        o_abort = 1'b1;
        n.idx = 2'h0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Checks
  a_key_done_code: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_done |-> i_cmd.addr[11:7] == 5'h07 && i_cmd.addr[6:0] == 7'h7f && i_cmd.ba == 2'h0)
    else $error("final key accepted with wrong code");
  // Keys one to three seen since arming, decoded apart from the sequencer
  assign key_field = i_cmd.addr[ppr_pkg::KEY_CODE_MSB:ppr_pkg::KEY_CODE_LSB];

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      seen_ff <= 3'h0;
    end else if (!i_arm || o_abort || o_done) begin
      seen_ff <= 3'h0;
    end else if (i_cmd.vld && i_cmd.op == ppr_pkg::OP_MRS) begin
      seen_ff <= seen_ff | {key_field == ppr_pkg::KEY_CODE3, key_field == ppr_pkg::KEY_CODE2,
        key_field == ppr_pkg::KEY_CODE1};
    end
  end

  a_key_order: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_done |-> seen_ff == 3'h7)
    else $error("final key accepted without prior keys");
endmodule // ppr_key_seq

//--- ppr_timer.sv
// Down counter with expiry strobe
`timescale 1ns/1ps
module ppr_timer #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic [W-1:0] i_load,
  output logic o_busy,
  output logic o_expire
);
  typedef struct packed {
    logic busy;
    logic [W-1:0] cnt;
  } ppr_tmr_st_t;

  ppr_tmr_st_t q;
  ppr_tmr_st_t n;

  if (W < 2) begin : g_chk
    $error("ppr_timer width too small");
  end

  // ==========================================================
  // Count down; expiry in the cycle the count is one
  always_comb begin
    n = q;
    o_busy = q.busy;
    o_expire = q.busy && q.cnt == W'(1);
    if (i_start) begin
      n.busy = i_load != '0;
      n.cnt = i_load;
    end else if (q.busy) begin
      n.cnt = q.cnt - W'(1);
      n.busy = q.cnt != W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule // ppr_timer

//--- ppr_ctrl.sv
// Post-package row repair controller, device side
// Summary of operation
// - MR4 bit 5 enters or leaves soft repair
// - Keys: BG/BA zero, low ones, fixed codes
// - Wrong or interrupted keys: no repair, NOP
// - After failed entry ACT/WR act normally; here both are ignored (no act_hit/act_assoc) until MR4 exit
// - Activate after keys captures seed bank/row
// - Repair only if all DQ low 4 clocks
// - One repair per bank, newer replaces older
// - Bank without resource ignores repair sequence
// - Reset reverts all banks to unrepaired
// - Seed row and masked-bit neighbours lose data
// - Alert low during self-test, high after
// - Self-test within 10 s, 20 s dual
// - Self-test completion sets status flag
`timescale 1ns/1ps
module ppr_ctrl #(
  parameter int DQ_W = 8,
  parameter int WL_W = 6,
  parameter bit DUAL_DIE = 1'b0,
  parameter longint SELFTEST_CYC =
    DUAL_DIE ? ppr_pkg::SELF_HEAL_DUAL_CYC : ppr_pkg::SELF_HEAL_MONO_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire ppr_pkg::ppr_cmd_t i_cmd,
  input wire logic [WL_W-1:0] i_wl,
  input wire logic [DQ_W-1:0] i_dq_rise,
  input wire logic [DQ_W-1:0] i_dq_fall,
  input wire logic [15:0] i_bank_res_ok,
  output logic o_soft_mode,
  output logic o_selftest_busy,
  output logic o_alert_n,
  output logic o_mpr3_flag,
  output logic o_commit,
  output logic o_act_hit,
  output logic o_act_assoc,
  output logic [15:0] o_rep_vld,
  output logic [15:0][17:0] o_rep_row
);
  ppr_pkg::ppr_ctrl_st_t q;
  ppr_pkg::ppr_ctrl_st_t n;
  logic key_arm;
  logic key_done;
  logic key_abort;
  logic wl_start;
  logic wl_expire;
  logic bist_start;
  logic bist_expire;
  logic is_mr4;
  logic is_act;
  logic is_wr;
  logic cur_hi;
  logic soft_st;
  logic [3:0] bank;
  logic [17:0] diff;

  // ==========================================================
  // Elaboration checks
  if (DQ_W < 1 || WL_W < 2 || SELFTEST_CYC < 2 || SELFTEST_CYC > 64'hffffffff) begin : g_chk
    $error("ppr_ctrl parameters out of range");
  end

  // ==========================================================
  // Submodules
  ppr_key_seq u_keys (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_arm(key_arm),
    .i_cmd(i_cmd),
    .o_done(key_done),
    .o_abort(key_abort)
  );

  ppr_timer #(.W(WL_W)) u_wl (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_start(wl_start),
    .i_load(i_wl - WL_W'(1)),
    .o_busy(),
    .o_expire(wl_expire)
  );

  ppr_timer #(.W(32)) u_bist (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_start(bist_start),
    .i_load(SELFTEST_CYC[31:0]),
    .o_busy(),
    .o_expire(bist_expire)
  );

  // ==========================================================
  // Command decode
  assign bank = {i_cmd.bg, i_cmd.ba};
  assign is_mr4 = i_cmd.vld && i_cmd.op == ppr_pkg::OP_MRS
    && {i_cmd.bg[0], i_cmd.ba} == ppr_pkg::MR_SEL_PPR;
  assign is_act = i_cmd.vld && i_cmd.op == ppr_pkg::OP_ACT;
  assign is_wr = i_cmd.vld && i_cmd.op == ppr_pkg::OP_WR;
  assign cur_hi = (|i_dq_rise) || (|i_dq_fall);
  assign key_arm = q.st == ppr_pkg::ST_SOFT_ARMED || q.st == ppr_pkg::ST_BIST_ARMED;
  assign soft_st = q.st inside {ppr_pkg::ST_SOFT_ARMED, ppr_pkg::ST_SOFT_KEYED,
    ppr_pkg::ST_SOFT_ACT, ppr_pkg::ST_SOFT_WL, ppr_pkg::ST_SOFT_DATA,
    ppr_pkg::ST_SOFT_DONE, ppr_pkg::ST_SOFT_FAIL};
  assign diff = i_cmd.addr ^ q.rep_row[bank];

  // ==========================================================
  // Next state
  always_comb begin
    n = q;
    n.commit = 1'b0;
    n.act_hit = 1'b0;
    n.act_assoc = 1'b0;
    wl_start = 1'b0;
    bist_start = 1'b0;
    unique case (q.st)
      ppr_pkg::ST_NORMAL: begin
        if (is_mr4 && i_cmd.addr[ppr_pkg::MR4_SOFT_BIT]) begin
          n.st = ppr_pkg::ST_SOFT_ARMED;
        end else if (is_mr4 && i_cmd.addr[ppr_pkg::MR4_SELFTEST_BIT]) begin
          n.st = ppr_pkg::ST_BIST_ARMED;
        end
        if (is_act && q.rep_vld[bank]) begin
          n.act_hit = diff == '0;
          n.act_assoc = diff != '0 && (diff & ~ppr_pkg::ASSOC_ROW_MASK) == '0;
        end
      end
      ppr_pkg::ST_SOFT_ARMED: begin
        if (key_done) begin
          n.st = ppr_pkg::ST_SOFT_KEYED;
        end else if (key_abort) begin
          n.st = ppr_pkg::ST_SOFT_FAIL;
        end
      end
      ppr_pkg::ST_SOFT_KEYED: begin
        if (is_act) begin
          if (i_bank_res_ok[bank]) begin
            n.seed_bank = bank;
            n.seed_row = i_cmd.addr;
            n.st = ppr_pkg::ST_SOFT_ACT;
          end else begin
            n.st = ppr_pkg::ST_SOFT_FAIL;
          end
        end
      end
      ppr_pkg::ST_SOFT_ACT: begin
        if (is_wr) begin
          if (bank == q.seed_bank) begin
            wl_start = 1'b1;
            n.st = ppr_pkg::ST_SOFT_WL;
          end else begin
            n.st = ppr_pkg::ST_SOFT_FAIL;
          end
        end
      end
      ppr_pkg::ST_SOFT_WL: begin
        if (wl_expire) begin
          n.st = ppr_pkg::ST_SOFT_DATA;
          n.beat = 2'h0;
          n.hi = 1'b0;
        end
      end
      ppr_pkg::ST_SOFT_DATA: begin
        n.hi = q.hi || cur_hi;
        n.beat = q.beat + 2'h1;
        if (q.beat == 2'(ppr_pkg::DATA_BEATS - 1)) begin
          n.st = ppr_pkg::ST_SOFT_DONE;
          if (!(q.hi || cur_hi)) begin
            n.rep_vld[q.seed_bank] = 1'b1;
            n.rep_row[q.seed_bank] = q.seed_row;
            n.commit = 1'b1;
          end
        end
      end
      ppr_pkg::ST_SOFT_DONE, ppr_pkg::ST_SOFT_FAIL: begin
        n.st = q.st;
      end
      ppr_pkg::ST_BIST_ARMED: begin
        if (key_done) begin
          bist_start = 1'b1;
          n.alert_n = 1'b0;
          n.st = ppr_pkg::ST_BIST_RUN;
        end else if (key_abort) begin
          n.st = ppr_pkg::ST_NORMAL;
        end
      end
      ppr_pkg::ST_BIST_RUN: begin
        if (bist_expire) begin
          n.alert_n = 1'b1;
          n.mpr3_flag = 1'b1;
          n.st = ppr_pkg::ST_NORMAL;
        end
      end
    endcase
    if (soft_st && is_mr4 && !i_cmd.addr[ppr_pkg::MR4_SOFT_BIT]) begin
      n.st = ppr_pkg::ST_NORMAL;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
      q.alert_n <= 1'b1;
      q.st <= ppr_pkg::ST_NORMAL;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign o_soft_mode = soft_st;
  assign o_selftest_busy = q.st == ppr_pkg::ST_BIST_RUN;
  assign o_alert_n = q.alert_n;
  assign o_mpr3_flag = q.mpr3_flag;
  assign o_commit = q.commit;
  assign o_act_hit = q.act_hit;
  assign o_act_assoc = q.act_assoc;
  assign o_rep_vld = q.rep_vld;
  assign o_rep_row = q.rep_row;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  logic [31:0] run_cnt;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_cnt <= 32'h0;
    end else if (q.st == ppr_pkg::ST_BIST_RUN) begin
      run_cnt <= run_cnt + 32'h1;
    end else begin
      run_cnt <= 32'h0;
    end
  end

  a_soft_entry: assert property (
    q.st == ppr_pkg::ST_NORMAL && is_mr4 && i_cmd.addr[5] |=> o_soft_mode)
    else $error("soft repair not entered");
  a_keys_abort: assert property (
    q.st == ppr_pkg::ST_SOFT_ARMED && key_abort && !is_mr4 |=> q.st == ppr_pkg::ST_SOFT_FAIL)
    else $error("broken key sequence did not fail");
  a_fail_normal: assert property (
    q.st == ppr_pkg::ST_SOFT_FAIL |=> $stable(o_rep_vld) && $stable(o_rep_row))
    else $error("repair changed after failed entry");
  a_seed_capture: assert property (
    q.st == ppr_pkg::ST_SOFT_KEYED && is_act && i_bank_res_ok[bank]
    |=> q.seed_row == $past(i_cmd.addr) && q.seed_bank == $past(bank))
    else $error("seed row not captured");
  a_high_blocks: assert property (
    q.st == ppr_pkg::ST_SOFT_DATA && cur_hi |=> (!o_commit) [*4])
    else $error("repair despite high data");
  a_commit_store: assert property (
    o_commit |-> o_rep_vld[q.seed_bank] && o_rep_row[q.seed_bank] == q.seed_row)
    else $error("committed repair not stored");
  a_no_resource: assert property (
    q.st == ppr_pkg::ST_SOFT_KEYED && is_act && !i_bank_res_ok[bank] && !is_mr4
    |=> q.st == ppr_pkg::ST_SOFT_FAIL ##1 !o_commit)
    else $error("repair accepted without resource");
  a_alert_run: assert property (
    o_selftest_busy |-> !o_alert_n)
    else $error("alert high during self-test");
  a_alert_done: assert property (
    $rose(o_alert_n) |-> o_mpr3_flag && $past(o_selftest_busy))
    else $error("self-test end without status flag");
  a_bist_bound: assert property (
    run_cnt <= SELFTEST_CYC[31:0])
    else $error("self-test exceeded time limit");

  c_soft_commit: cover property (o_commit);
  c_key_fail: cover property (q.st == ppr_pkg::ST_SOFT_FAIL);
  c_bist_done: cover property ($rose(o_alert_n));
  c_assoc_act: cover property (o_act_assoc);
endmodule // ppr_ctrl

//--- ppr_host_model.sv
// Memory controller model driving the command and DQ lines
`timescale 1ns/1ps
module ppr_host_model #(
  parameter int MOD_CYC = 4,
  parameter int RCD_CYC = 3,
  parameter int WR_CYC = 4
) (
  input wire logic i_clk,
  output ppr_pkg::ppr_cmd_t o_cmd,
  output logic [7:0] o_dq_rise,
  output logic [7:0] o_dq_fall
);
  // ==========================================================
  // Idle bus
  initial begin
    o_cmd = '0;
    o_dq_rise = 8'hff;
    o_dq_fall = 8'hff;
  end

  // ==========================================================
  // Command tasks
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic cmd(input ppr_pkg::ppr_op_t op, input logic [3:0] bank, input logic [17:0] a);
    @(posedge i_clk);
    o_cmd <= '{vld: 1'b1, op: op, bg: bank[3:2], ba: bank[1:0], addr: a};
    @(posedge i_clk);
    o_cmd <= '{vld: 1'b1, op: ppr_pkg::OP_DES, bg: 2'h0, ba: 2'h0, addr: 18'h0};
  endtask

  task automatic mr4(input logic [17:0] a);
    cmd(ppr_pkg::OP_MRS, 4'h4, a);
    idle(MOD_CYC);
  endtask

  // Mode 0 clean, 1 to 4 interrupt before the third key, 5 swaps keys two and three
  task automatic keys(input int mode);
    ppr_pkg::ppr_op_t iop[5] = '{ppr_pkg::OP_DES, ppr_pkg::OP_NOP, ppr_pkg::OP_MRS,
                                 ppr_pkg::OP_PRE, ppr_pkg::OP_ZQ};
    logic [4:0] kc[4] = '{5'h19, 5'h0f, 5'h17, 5'h07};
    int idx;
    for (int i = 0; i < 4; i++) begin
      if (mode >= 1 && mode <= 4 && i == 2) begin
        cmd(iop[mode], 4'h2, 18'h0);
      end
      idx = (mode == 5 && i == 1) ? 2 : (mode == 5 && i == 2) ? 1 : i;
      cmd(ppr_pkg::OP_MRS, 4'h0, {6'h0, kc[idx], 7'h7f});
      idle(MOD_CYC);
    end
  endtask

  // Activate, write, then four data clocks; no refresh inside the frame
  task automatic repair(input logic [3:0] bank, input logic [17:0] row, input int wl,
                        input logic bad);
    cmd(ppr_pkg::OP_ACT, bank, row);
    idle(RCD_CYC);
    cmd(ppr_pkg::OP_WR, bank, 18'h0);
    idle(wl - 1);
    for (int i = 0; i < 4; i++) begin
      o_dq_rise <= 8'h00;
      o_dq_fall <= (bad && i == 2) ? 8'h10 : 8'h00;
      @(posedge i_clk);
    end
    o_dq_rise <= 8'hff;
    o_dq_fall <= 8'hff;
  endtask

  task automatic close(input logic [3:0] bank);
    idle(WR_CYC);
    cmd(ppr_pkg::OP_PRE, bank, 18'h0);
    idle(ppr_pkg::SOFT_PRE_EXIT_CYC);
    mr4(18'h0);
  endtask
endmodule // ppr_host_model

//--- tb.sv
// Self-checking testbench for the row repair controller
`timescale 1ns/1ps
module tb;
  localparam int SC = 50;
  localparam int WL = 5;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] res_ok = 16'hffff;
  ppr_pkg::ppr_cmd_t cmd;
  logic [7:0] dq_r;
  logic [7:0] dq_f;
  logic soft_mode, busy, alert_n, mpr3, commit, hit, assoc;
  logic [15:0] rep_vld;
  logic [15:0][17:0] rep_row;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;

  always #5 clk = ~clk;

  ppr_host_model host_u (.i_clk(clk), .o_cmd(cmd), .o_dq_rise(dq_r), .o_dq_fall(dq_f));

  ppr_ctrl #(.SELFTEST_CYC(SC)) dut_u (
    .i_clk(clk), .i_rstn(rstn), .i_cmd(cmd), .i_wl(6'h5), .i_dq_rise(dq_r),
    .i_dq_fall(dq_f), .i_bank_res_ok(res_ok), .o_soft_mode(soft_mode),
    .o_selftest_busy(busy), .o_alert_n(alert_n), .o_mpr3_flag(mpr3), .o_commit(commit),
    .o_act_hit(hit), .o_act_assoc(assoc), .o_rep_vld(rep_vld), .o_rep_row(rep_row)
  );

  // ==========================================================
  // Compare and report
  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic chk_vec(input string what, input logic [17:0] exp, input logic [17:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      test_done();
    end
  end

  // ==========================================================
  // Scenario tasks
  task automatic run_soft(input logic [3:0] b, input logic [17:0] row, input logic bad,
                          input int mode, input logic exp);
    host_u.mr4(18'h20);
    #1;
    chk_bit("soft_mode", 1'b1, soft_mode);
    host_u.keys(mode);
    host_u.repair(b, row, WL, bad);
    #1;
    chk_bit("commit", exp, commit);
    host_u.close(b);
    #1;
    chk_bit("soft_mode", 1'b0, soft_mode);
  endtask

  task automatic look(input logic [3:0] b, input logic [17:0] row, input logic eh,
                      input logic ea);
    host_u.cmd(ppr_pkg::OP_ACT, b, row);
    #1;
    chk_bit("act_hit", eh, hit);
    chk_bit("act_assoc", ea, assoc);
    host_u.cmd(ppr_pkg::OP_PRE, b, 18'h0);
  endtask

  task automatic do_reset;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk_vec("rep_vld", 18'h0, {2'h0, rep_vld});
    chk_bit("mpr3", 1'b0, mpr3);
    chk_bit("alert_n", 1'b1, alert_n);
    chk_bit("soft_mode", 1'b0, soft_mode);
    @(posedge clk);
    rstn <= 1'b1;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    do_reset();
    run_soft(4'h5, 18'h12344, 1'b0, 0, 1'b1);
    chk_bit("rep_vld5", 1'b1, rep_vld[5]);
    chk_vec("rep_row5", 18'h12344, rep_row[5]);
    look(4'h5, 18'h12344, 1'b1, 1'b0);
    look(4'h5, 18'h32344, 1'b0, 1'b1);
    look(4'h5, 18'h12345, 1'b0, 1'b1);
    look(4'h5, 18'h12340, 1'b0, 1'b0);
    look(4'h6, 18'h12344, 1'b0, 1'b0);
    run_soft(4'h5, 18'h0abcd, 1'b0, 0, 1'b1);
    chk_vec("rep_row5", 18'h0abcd, rep_row[5]);
    run_soft(4'h3, 18'h12344, 1'b1, 0, 1'b0);
    chk_bit("rep_vld3", 1'b0, rep_vld[3]);
    for (int m = 1; m <= 5; m++) begin
      run_soft(4'h7, 18'h00100, 1'b0, m, 1'b0);
      chk_bit("rep_vld7", 1'b0, rep_vld[7]);
      look(4'h7, 18'h00100, 1'b0, 1'b0);
    end
    @(posedge clk);
    res_ok <= 16'hfdff;
    run_soft(4'h9, 18'h00100, 1'b0, 0, 1'b0);
    chk_bit("rep_vld9", 1'b0, rep_vld[9]);
    @(posedge clk);
    res_ok <= 16'hffff;
    run_soft(4'hc, 18'h3ffff, 1'b0, 0, 1'b1);
    chk_vec("rep_row12", 18'h3ffff, rep_row[12]);
    chk_vec("rep_row5", 18'h0abcd, rep_row[5]);
    do_reset();
    host_u.mr4(18'h1);
    host_u.keys(0);
    #1;
    chk_bit("alert_n", 1'b0, alert_n);
    chk_bit("busy", 1'b1, busy);
    n = 0;
    while (alert_n !== 1'b1 && n < SC + 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    #1;
    chk_bit("heal_time", 1'b1, n <= SC);
    chk_bit("alert_n", 1'b1, alert_n);
    chk_bit("mpr3", 1'b1, mpr3);
    chk_bit("busy", 1'b0, busy);
    host_u.mr4(18'h1);
    host_u.keys(5);
    #1;
    chk_bit("busy", 1'b0, busy);
    chk_bit("alert_n", 1'b1, alert_n);
    do_reset();
    test_done();
  end
endmodule // tb
